/* File: verilog/sr_blank_timing.sv */
// Purpose: Gate timing of a synchronous rectifier with fixed on-blanking and adaptive off-blanking
// Assumes: Comparator results arrive as asynchronous levels; reset follows supply lockout
// Notes: Pin synchronising adds two clocks of latency ahead of every decision
`timescale 1ns/100ps
module sr_blank_timing #(
  parameter int CW = 12
) (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Comparator pins
  input wire logic turn_on_cmp,
  input wire logic turn_off_cmp,
  input wire logic rearm_cmp,
  // Supply and variant pins
  input wire logic uv_flag,
  input wire logic long_variant,
  // Gate drive
  output logic gate_drive_out,
  // Status
  output logic armed,
  output logic off_blanking,
  output logic false_turn_on
);
  import sr_timing_pkg::*;

  if (CW < 8 || CW > 16)
  begin : g_chk
    $error("sr_blank_timing counter width must be 8 to 16");
  end

  localparam logic [CW-1:0] MIN_ON_S = CW'(MIN_ON_SHORT_CYC);
  localparam logic [CW-1:0] MIN_ON_L = CW'(MIN_ON_LONG_CYC);
  localparam logic [CW-1:0] ABS_MIN = CW'(ABS_MIN_OFF_CYC);
  localparam logic [CW-1:0] MAX_OFF = CW'(MAX_OFF_CYC);
  localparam logic [CW+4:0] DIV = (CW+5)'(RATIO_DIV);

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] x);
    sat_inc = (&x) ? x : x + 1'b1;
  endfunction

  // Saturates rather than wraps so long off times still hit the ceiling
  function automatic logic [CW-1:0] scale10(input logic [CW-1:0] x, input logic [4:0] k);
    logic [CW+4:0] p;
    p = ({5'h00, x} * {{CW{1'b0}}, k}) / DIV;
    scale10 = (|p[CW+4:CW]) ? {CW{1'b1}} : p[CW-1:0];
  endfunction

  function automatic logic [CW-1:0] max2(input logic [CW-1:0] a, input logic [CW-1:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_s;
  logic on_s;
  logic off_s;
  logic rearm_s;
  logic uv_s;
  logic long_s;

  sr_state_type state_r;
  sr_state_type state_nxt;
  logic gate_r;
  logic gate_nxt;
  logic [CW-1:0] timer_r;
  logic [CW-1:0] timer_nxt;
  logic [CW-1:0] diode_r;
  logic [CW-1:0] diode_nxt;
  logic [CW-1:0] off_cnt_r;
  logic [CW-1:0] off_cap_r;
  logic [CW-1:0] prev_off_r;
  logic [CW-1:0] ring_r;
  logic ring_valid_r;
  logic [CW-1:0] blank_len_r;
  logic false_r;

  logic [CW-1:0] min_on;
  logic [CW-1:0] timer_inc;
  logic blank_done;
  logic min_on_done;
  logic diode_seen;
  logic diode_long;
  logic [CW-1:0] clamp_part;
  logic [CW-1:0] off_part;
  logic [CW-1:0] blank_raw;
  logic [CW-1:0] blank_nxt;
  logic enter_blank;
  logic gate_rise;
  logic gate_fall;
  logic go_real;
  logic go_false;

  assign pins_raw = {long_variant, uv_flag, rearm_cmp, turn_off_cmp, turn_on_cmp};

  pin_sync #(
    .W(PIN_COUNT)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in(pins_raw),
    .pin_sync_out(pins_s)
  );

  assign on_s = pins_s[PIN_ON];
  assign off_s = pins_s[PIN_OFF];
  assign rearm_s = pins_s[PIN_REARM];
  assign uv_s = pins_s[PIN_UV];
  assign long_s = pins_s[PIN_LONG];

  assign min_on = long_s ? MIN_ON_L : MIN_ON_S;
  assign timer_inc = sat_inc(timer_r);
  assign blank_done = timer_inc >= blank_len_r;
  assign min_on_done = timer_inc >= min_on;
  // Conduction at the expiry itself counts too, the riskiest case
  assign diode_seen = on_s || (diode_r != '0);
  assign diode_long = diode_r > min_on;

  // Blanking length is frozen at the start of off-blanking
  assign clamp_part = ring_valid_r ? scale10(ring_r, RING_CLAMP_X10) : ABS_MIN;
  assign off_part = scale10(prev_off_r, OFF_PART_X10);
  assign blank_raw = max2(ABS_MIN, max2(clamp_part, off_part));
  assign blank_nxt = (blank_raw > MAX_OFF) ? MAX_OFF : blank_raw;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_DISABLED:
        state_nxt = ST_WAIT_RISE;
      ST_WAIT_RISE:
        if (rearm_s)
          state_nxt = ST_BLANK;
      ST_BLANK:
        if (blank_done)
          state_nxt = diode_seen ? ST_SKIP : ST_ARMED;
      ST_ARMED:
        if (on_s)
          state_nxt = ST_ON_MIN;
      ST_ON_MIN:
        if (min_on_done)
          state_nxt = off_s ? ST_WAIT_RISE : ST_ON;
      ST_ON:
        if (off_s)
          state_nxt = ST_WAIT_RISE;
      ST_SKIP:
        if (!on_s && rearm_s)
          state_nxt = ST_BLANK;
      default:
        state_nxt = ST_DISABLED;
    endcase
    if (uv_s)
      state_nxt = ST_DISABLED;
  end

  assign gate_nxt = (state_nxt == ST_ON_MIN) || (state_nxt == ST_ON);
  assign enter_blank = (state_nxt == ST_BLANK) && (state_r != ST_BLANK);
  assign gate_rise = gate_nxt && !gate_r;
  assign gate_fall = gate_r && !gate_nxt;
  assign go_real = (state_r == ST_ON) && (state_nxt == ST_WAIT_RISE);
  assign go_false = (state_r == ST_ON_MIN) && (state_nxt == ST_WAIT_RISE);
  assign timer_nxt = (state_nxt != state_r) ? '0 : timer_inc;
  assign diode_nxt = (state_nxt == ST_BLANK && state_r == ST_BLANK && on_s) ? sat_inc(diode_r) :
                     (state_nxt == ST_BLANK && state_r == ST_BLANK) ? diode_r : '0;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_DISABLED;
      gate_r <= 1'b0;
      timer_r <= '0;
      diode_r <= '0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      gate_r <= gate_nxt;
      timer_r <= timer_nxt;
      diode_r <= diode_nxt;
    end
  end

  // Off time runs from gate-off to the next turn-on
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      off_cnt_r <= '0;
      off_cap_r <= '0;
      prev_off_r <= '0;
    end
    else if (clk_en)
    begin
      off_cnt_r <= gate_fall ? '0 : sat_inc(off_cnt_r);
      if (gate_rise)
        off_cap_r <= off_cnt_r;
      if (go_real)
        prev_off_r <= off_cap_r;
    end
  end

  // A false turn-on and a diode reset never share a cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ring_r <= '0;
      ring_valid_r <= 1'b0;
      blank_len_r <= ABS_MIN;
      false_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (go_false)
      begin
        ring_r <= off_cap_r;
        ring_valid_r <= 1'b1;
      end
      else if (state_r == ST_BLANK && diode_long)
        ring_valid_r <= 1'b0;
      if (enter_blank)
        blank_len_r <= blank_nxt;
      false_r <= go_false;
    end
  end

  assign gate_drive_out = gate_r;
  assign armed = (state_r == ST_ARMED);
  assign off_blanking = (state_r == ST_BLANK);
  assign false_turn_on = false_r;

  // Assertion helper: length of the current gate pulse
  logic [CW-1:0] ast_on_len_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ast_on_len_r <= '0;
    else if (clk_en)
      ast_on_len_r <= gate_r ? sat_inc(ast_on_len_r) : '0;
  end

  default clocking cb @(posedge clk iff clk_en);
  endclocking
  default disable iff (!resetn);

  AST_MIN_ON: assert property ($fell(gate_r) && !$past(uv_s) |-> ast_on_len_r >= min_on)
    else $error("gate pulse shorter than minimum on-time");
  AST_BLANK_FLOOR: assert property (state_r == ST_BLANK |-> blank_len_r >= ABS_MIN)
    else $error("off-blanking below absolute minimum");
  AST_BLANK_OFF_PART: assert property ($rose(off_blanking) && !$past(ring_valid_r)
    && scale10($past(prev_off_r), OFF_PART_X10) <= MAX_OFF
    |-> blank_len_r == max2(ABS_MIN, scale10($past(prev_off_r), OFF_PART_X10)))
    else $error("off-blanking not 70 percent of previous off time");
  AST_RING_REC: assert property (go_false |=> ring_valid_r && ring_r == $past(off_cap_r))
    else $error("ring cycle not recorded on false turn-on");
  AST_RING_CLAMP: assert property ($rose(off_blanking) && $past(ring_valid_r)
    |-> blank_len_r >= ((scale10($past(ring_r), RING_CLAMP_X10) > MAX_OFF) ? MAX_OFF
        : scale10($past(ring_r), RING_CLAMP_X10)))
    else $error("ring clamp not applied");
  AST_CLAMP_RESET: assert property (state_r == ST_BLANK && diode_long && !go_false |=> !ring_valid_r)
    else $error("clamp not reset after long diode conduction");
  AST_SKIP: assert property (state_r == ST_BLANK && blank_done && diode_seen && !uv_s
    |=> state_r == ST_SKIP ##1 !gate_r)
    else $error("turn-on not skipped after late blanking");
  AST_BLANK_MAX: assert property (off_blanking |-> blank_len_r <= MAX_OFF)
    else $error("off-blanking above maximum");
  AST_GATE_ARMED: assert property ($rose(gate_r) |-> $past(state_r) == ST_ARMED)
    else $error("gate rose without arming");
  AST_ARM_AFTER: assert property ($rose(armed) |-> $past(state_r) == ST_BLANK && $past(blank_done))
    else $error("armed before blanking elapsed");
  AST_BLANK_START: assert property ($rose(off_blanking) |-> $past(rearm_s))
    else $error("blanking started without re-arm comparator");
  AST_UV_OFF: assert property (uv_s |=> !gate_r && state_r == ST_DISABLED)
    else $error("gate not held off in undervoltage");
  AST_TURN_OFF: assert property (state_r == ST_ON && off_s |=> !gate_r)
    else $error("gate not turned off by turn-off comparator");

  // Hold and response checks between the decision points
  AST_ON_HOLD: assert property (state_r == ST_ON_MIN && !min_on_done && !uv_s |=> gate_r)
    else $error("gate released inside minimum on-time");
  AST_FALSE_PULSE: assert property (false_turn_on |=> !false_turn_on)
    else $error("false turn-on flag longer than one cycle");
  AST_DIODE_COUNT: assert property (off_blanking && on_s && !blank_done && !uv_s |=> diode_r != '0)
    else $error("diode conduction not counted during blanking");
  AST_SKIP_HOLD: assert property (state_r == ST_SKIP && on_s && !uv_s |=> state_r == ST_SKIP)
    else $error("skipped cycle left while diode conducts");
  AST_ARMED_WAIT: assert property (armed && !on_s && !uv_s |=> armed)
    else $error("armed state left without turn-on");
  AST_NO_GATE_BLANK: assert property ((off_blanking || state_r == ST_SKIP) |-> !gate_r)
    else $error("gate on during blanking or skip");
  AST_BLANK_ZERO: assert property ($rose(off_blanking) |-> timer_r == '0)
    else $error("off-blanking timer did not start from zero");
  AST_REARM_WAIT: assert property (state_r == ST_WAIT_RISE && !rearm_s && !uv_s |=> !off_blanking)
    else $error("blanking started before re-arm");
  AST_ON_RESPONSE: assert property (armed && on_s && !uv_s |=> gate_r)
    else $error("gate not turned on by turn-on comparator");

  COV_FALSE: cover property (go_false);
  COV_REAL: cover property (go_real);
  COV_SKIP: cover property (state_r == ST_SKIP);
  COV_RESET_CLAMP: cover property ($fell(ring_valid_r));
  COV_LONG_ON: cover property ($fell(gate_r) && long_s);

endmodule

/* File: verilog/sr_timing_pkg.sv */
// Purpose: Shared constants and state type for the rectifier blanking timing logic
// Assumes: A 25 MHz internal timing clock
// Notes: All times are kept in ns, and the cycle counts are derived from them
//
// Functional notes
// - Gate stays on for 360 ns, or 540 ns in the long variant, whatever turn-off shows
// - Off-blanking is the largest of 400 ns, the ring clamp and the off-time part
// - The off-time part is 70 percent of the previous cycle's off time
// - Conduction no longer than min on-time is false; record off-to-turn-on interval
// - The next cycle clamps off-blanking at 2.2 times the recorded ring cycle
// - Diode conduction longer than min on-time during blanking drops clamp to 400 ns
// - If blanking expires after diode conduction began, skip turn-on this cycle
// - Off-blanking never exceeds 3.68 us
// - Gate may turn on only while the turn-on path is armed
// - Arm the turn-on path only after off-blanking has fully elapsed
// - Off-blanking timer starts only on the drain-above-source re-arm comparator
// - Undervoltage disables all control and holds the gate off
// - Outside blanking, gate follows the turn-on and turn-off comparators
package sr_timing_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MIN_ON_SHORT_NS = 360;
  localparam int unsigned MIN_ON_LONG_NS = 540;
  localparam int unsigned ABS_MIN_OFF_NS = 400;
  localparam int unsigned MAX_OFF_NS = 3680;

  // Least times round up, the longest time rounds down
  localparam int unsigned MIN_ON_SHORT_CYC = (MIN_ON_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_ON_LONG_CYC = (MIN_ON_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ABS_MIN_OFF_CYC = (ABS_MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAX_OFF_CYC = MAX_OFF_NS / CLK_PERIOD_NS;

  // Ratios in tenths
  localparam logic [4:0] OFF_PART_X10 = 5'h07;
  localparam logic [4:0] RING_CLAMP_X10 = 5'h16;
  localparam int unsigned RATIO_DIV = 10;

  // Pin vector positions behind the synchroniser
  localparam int unsigned PIN_ON = 0;
  localparam int unsigned PIN_OFF = 1;
  localparam int unsigned PIN_REARM = 2;
  localparam int unsigned PIN_UV = 3;
  localparam int unsigned PIN_LONG = 4;
  localparam int unsigned PIN_COUNT = 5;

  typedef enum logic [2:0] {
    ST_DISABLED = 3'h0,
    ST_WAIT_RISE = 3'h1,
    ST_BLANK = 3'h2,
    ST_ARMED = 3'h3,
    ST_ON_MIN = 3'h4,
    ST_ON = 3'h5,
    ST_SKIP = 3'h6
  } sr_state_type;

endpackage

/* File: verilog/pin_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous comparator and supply pins
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);

  logic [W-1:0] meta_r;

  if (W < 1)
  begin : g_chk
    $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      pin_sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_r <= pin_in;
      pin_sync_out <= meta_r;
    end
  end

endmodule

/* File: verification/rect_sense_model.sv */
// Purpose: Drain and source sense comparators of the rectifier MOSFET
// Assumes: The bench sets the phase between clock edges
// Notes: Phase 0 no current, 1 drain high, 2 current flowing; 3 acts as 0
`timescale 1ns/100ps
module rect_sense_model (
  // Phase select
  input wire logic [1:0] phase,
  // Comparator results
  output logic turn_on_cmp,
  output logic turn_off_cmp,
  output logic rearm_cmp
);
  // Below turn-on only while current flows, gate or no gate
  assign turn_on_cmp = (phase == 2'h2);
  // Above turn-off whenever no current flows, so a short pulse is seen as false
  assign turn_off_cmp = (phase != 2'h2);
  assign rearm_cmp = (phase == 2'h1);
endmodule

/* File: verification/sr_adaptive_blanking_timing_tb_top.sv */
// Purpose: Self-checking bench of the rectifier gate timing
// Assumes: Short counts kept, clock enable held high
// Notes: Blank lengths counted on falling edges while off_blanking is high
`timescale 1ns/100ps
module sr_adaptive_blanking_timing_tb_top;
  import sr_timing_pkg::*;
  logic clk, resetn, uv_flag, long_variant, gate_q, seen;
  logic [1:0] phase;
  logic turn_on_cmp, turn_off_cmp, rearm_cmp;
  logic gate_drive_out, armed, off_blanking, false_turn_on;
  int miscompares, samples_checked, run_len, last_len, n, blank, off_prev;
  rect_sense_model far_u (.phase(phase), .turn_on_cmp(turn_on_cmp), .turn_off_cmp(turn_off_cmp),
    .rearm_cmp(rearm_cmp));
  sr_blank_timing #(.CW(12)) dut_u (.clk(clk), .resetn(resetn), .clk_en(1'b1),
    .turn_on_cmp(turn_on_cmp), .turn_off_cmp(turn_off_cmp), .rearm_cmp(rearm_cmp),
    .uv_flag(uv_flag), .long_variant(long_variant), .gate_drive_out(gate_drive_out),
    .armed(armed), .off_blanking(off_blanking), .false_turn_on(false_turn_on));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Length of the last finished gate level, for the off-time expectation
  always @(negedge clk)
  begin
    if (gate_drive_out === gate_q) run_len = run_len + 1;
    else
    begin
      last_len = run_len;
      run_len = 1;
    end
    gate_q = gate_drive_out;
  end
  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %0t %s", $time, what);
    end
  endtask
  task automatic check_int(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("unexpected %0t %s got %0d", $time, what, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_gate;
    for (n = 0; n < 5 && gate_drive_out !== 1'b1; n++) cyc(1);
  endtask
  task automatic blank_phase;
    phase = 2'h1;
    for (n = 0; n < 6 && off_blanking !== 1'b1; n++) cyc(1);
    for (blank = 0; blank < 200 && off_blanking === 1'b1; blank++) cyc(1);
    check_bit(armed, 1'b1, "not armed after blanking");
  endtask
  task automatic conduct_real(input int hold);
    cyc(hold);
    check_bit(gate_drive_out, 1'b0, "gate on without turn-on");
    phase = 2'h2;
    wait_gate();
    check_bit(gate_drive_out, 1'b1, "gate not on");
    cyc(20);
    off_prev = last_len;
    phase = 2'h0;
    cyc(3);
    check_bit(gate_drive_out, 1'b0, "gate not off");
    cyc(10);
    check_bit(off_blanking, 1'b0, "blanking without re-arm");
  endtask
  task automatic test_adaptive;
    blank_phase();
    check_int(blank, 10, 10, "first blank");
    conduct_real(2);
    blank_phase();
    conduct_real(150);
    blank_phase();
    check_int(blank, 92, 92, "blank above max");
    conduct_real(0);
    blank_phase();
    check_int(blank, 7 * off_prev / 10 - 1, 7 * off_prev / 10 + 1, "off-time part");
    conduct_real(0);
  endtask
  task automatic test_false(input logic lv, input int mon);
    long_variant = lv;
    cyc(4);
    blank_phase();
    phase = 2'h2;
    wait_gate();
    phase = 2'h0;
    // Turn-off is high from here on, so only the minimum on-time holds the gate
    for (n = 0; n < 30 && gate_drive_out === 1'b1; n++) cyc(1);
    check_int(n, mon, mon, "minimum on-time");
    for (n = 0; n < 3 && false_turn_on !== 1'b1; n++) cyc(1);
    check_bit(false_turn_on, 1'b1, "no false turn-on flag");
    long_variant = 1'b0;
    cyc(5);
  endtask
  task automatic test_skip;
    phase = 2'h1;
    for (n = 0; n < 6 && off_blanking !== 1'b1; n++) cyc(1);
    cyc(2);
    phase = 2'h2;
    seen = 1'b0;
    // Diode held past the blank expiry; that cycle must be skipped
    repeat (100)
    begin
      cyc(1);
      if (gate_drive_out !== 1'b0 || armed !== 1'b0) seen = 1'b1;
    end
    check_bit(seen, 1'b0, "gate on in skipped cycle");
    check_bit(off_blanking, 1'b0, "blanking past expiry");
    // Long diode conduction dropped the ring clamp; only the off-time part remains
    blank_phase();
    check_int(blank, 7 * off_prev / 10 - 1, 7 * off_prev / 10 + 1, "clamp not reset");
  endtask
  task automatic test_uv;
    phase = 2'h2;
    wait_gate();
    uv_flag = 1'b1;
    cyc(3);
    check_bit(gate_drive_out, 1'b0, "gate on in undervoltage");
    check_bit(armed, 1'b0, "armed in undervoltage");
    phase = 2'h0;
    cyc(5);
    uv_flag = 1'b0;
    cyc(4);
  endtask
  task automatic finish_test;
    $display("checked %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    uv_flag = 1'b0;
    long_variant = 1'b0;
    phase = 2'h0;
    gate_q = 1'b0;
    cyc(12);
    check_bit(gate_drive_out, 1'b0, "gate on in reset");
    resetn = 1'b1;
    cyc(4);
    test_adaptive();
    test_false(1'b0, 9);
    test_false(1'b1, 14);
    test_skip();
    test_uv();
    finish_test();
  end
  // Whole run is near 900 clocks
  initial
  begin
    #(40 * 20000);
    miscompares++;
    $display("unexpected %0t watchdog", $time);
    finish_test();
  end
endmodule
